// ### hdl/diag_pkg.sv
package diag_pkg;
    // =====================================================================
    // Register map (printed offsets are word indices; byte addr = 4*index).
    // =====================================================================
    localparam logic [7:0] IDX_ERR_CAT   = 8'h00;
    localparam logic [7:0] IDX_CLASS     = 8'h01;
    localparam logic [7:0] IDX_INT_SUP   = 8'h02;
    localparam logic [7:0] IDX_ZERO      = 8'h03;
    localparam logic [7:0] IDX_IN_BYTE3  = 8'h04;
    localparam logic [7:0] IDX_CTRL      = 8'h05;
    localparam logic [7:0] IDX_STATUS    = 8'h06;
    localparam logic [7:0] IDX_IRQ_STAT  = 8'h07;
    localparam logic [7:0] IDX_IRQ_MASK  = 8'h08;
    localparam logic [7:0] IDX_ERR_SRC   = 8'h09;
    localparam logic [11:0] ADDR_ERR_CAT  = 12'h000;
    localparam logic [11:0] ADDR_CLASS    = 12'h004;
    localparam logic [11:0] ADDR_INT_SUP  = 12'h008;
    localparam logic [11:0] ADDR_ZERO     = 12'h00c;
    localparam logic [11:0] ADDR_IN_BYTE3 = 12'h010;
    localparam logic [11:0] ADDR_CTRL     = 12'h014;
    localparam logic [11:0] ADDR_STATUS   = 12'h018;
    localparam logic [11:0] ADDR_IRQ_STAT = 12'h01c;
    localparam logic [11:0] ADDR_IRQ_MASK = 12'h020;
    localparam logic [11:0] ADDR_ERR_SRC  = 12'h024;
    // =====================================================================
    // Field positions.
    // =====================================================================
    localparam int B0_FAIL    = 0;
    localparam int B0_INTERN  = 1;
    localparam int B0_EXTERN  = 2;
    localparam int B0_CHAN    = 3;
    localparam int B0_EXTSUP  = 4;
    localparam int B1_CHINFO  = 4;
    localparam int B2_INTSUP  = 4;
    localparam int B3_PILOST  = 6;
    localparam int CTRL_REL   = 0;
    localparam int CTRL_FUNC  = 1;
    localparam int CTRL_ACK   = 2;
    localparam int ST_PEND    = 0;
    localparam int ST_ERR     = 1;
    localparam int IRQ_OUT    = 0;
    localparam int IRQ_IN     = 1;
    // Error source vector bits.
    localparam int SRC_PILOST = 0;
    localparam int SRC_SUPPLY = 1;
    localparam int SRC_SHORT  = 2;
    localparam int SRC_BUSSUP = 3;
    localparam int SRC_MODDIAG = 4;
    localparam int SRC_W      = 5;
    localparam logic [3:0] CLASS_DIGITAL  = 4'hf;
    localparam logic [3:0] CLASS_FUNCTION = 4'h8;
    localparam logic [31:0] CTRL_RESET    = 32'h0000_0000;
    localparam logic [1:0]  MASK_RESET    = 2'h0;
endpackage

// ### hdl/diag_rec_build.sv
`timescale 1ns/10ps
// =========================================================================
// Record assembly from error sources.
// =========================================================================
module diag_rec_build
    import diag_pkg::*;
(
    // Error sources and class select.
    input  wire logic [SRC_W-1:0] src,
    input  wire logic             func_mod,
    // Assembled record bytes.
    output logic      [7:0]       b0,
    output logic      [7:0]       b1,
    output logic      [7:0]       b2
);
    logic any_fail;  // Module failure has the widest cause set.

    // Byte contents are a pure function of the sources and the class select.
    always_comb begin
        any_fail = |src;
        b0 = 8'h00;  // Bits 7..5 stay zero.
        b0[B0_FAIL]   = any_fail;
        b0[B0_INTERN] = src[SRC_SUPPLY] | src[SRC_SHORT];
        b0[B0_EXTERN] = src[SRC_BUSSUP];
        b0[B0_CHAN]   = src[SRC_BUSSUP];
        b0[B0_EXTSUP] = src[SRC_BUSSUP];
        b1 = 8'h00;
        b1[3:0] = func_mod ? CLASS_FUNCTION : CLASS_DIGITAL;
        b1[B1_CHINFO] = any_fail;
        b2 = 8'h00;
        b2[B2_INTSUP] = src[SRC_SUPPLY];
    end
endmodule

// ### hdl/diag_clear_det.sv
`timescale 1ns/10ps
// =========================================================================
// Detects the edge at which an active error goes away, and its arrival.
// =========================================================================
module diag_clear_det (
    // Clock and reset.
    input  wire logic mclk,
    input  wire logic rst_n,
    // Combined error level.
    input  wire logic err,
    // Edge pulses.
    output logic      rise,
    output logic      fall
);
    logic err_q;  // Previous error level.
    logic err_d;  // Next error level.

    // Next value is the current level.
    always_comb begin
        err_d = err;
    end

    // Register the level.
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            err_q <= 1'b0;
        end else begin
            err_q <= err_d;
        end
    end

    assign rise = err & ~err_q;
    assign fall = ~err & err_q;
endmodule

// ### hdl/diag_record_out.sv
// Added by the designer: the APB register port.
`timescale 1ns/10ps
//
// Contract
// - Outgoing record only when release still enabled
// - Byte0 bit0 flags module failure
// - Byte0 bit1 flags internal error
// - Byte0 bit2 flags external error
// - Byte0 bit3 flags channel error
// - Byte0 bit4 missing external supply; 7..5 zero
// - Byte1 low nibble holds module class
// - Byte1 bit4 flags channel info present
// - Byte2 bit4 internal supply; byte3 zero
// - Same layout for all function types
// - Incoming byte3 bit6 flags lost interrupt
//
module diag_record_out
    import diag_pkg::*;
(
    // Clock and reset.
    input  wire logic             mclk,
    input  wire logic             rst_n,
    // APB slave.
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [11:0]      paddr,
    input  wire logic [31:0]      pwdata,
    output logic      [31:0]      prdata,
    output logic                  pready,
    output logic                  pslverr,
    // Error sources from the function unit.
    input  wire logic [SRC_W-1:0] err_src,
    // Interrupt.
    output logic                  irq
);
    // =====================================================================
    // State.
    // =====================================================================
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,  // No record pending.
        ST_ACT   = 3'b010,  // Error active, incoming record latched.
        ST_OUT   = 3'b100   // Outgoing record frozen for the reader.
    } rec_state_t;

    rec_state_t  st_q, st_d;          // Record state machine.
    logic [2:0]  ctrl_q, ctrl_d;      // Release, class and unused bit.
    logic [7:0]  r0_q, r0_d;          // Frozen record byte 0.
    logic [7:0]  r1_q, r1_d;          // Frozen record byte 1.
    logic [7:0]  r2_q, r2_d;          // Frozen record byte 2.
    logic [7:0]  in3_q, in3_d;        // Incoming record byte 3.
    logic [3:0]  rd_q, rd_d;          // Bytes collected, one bit each.
    logic [1:0]  ist_q, ist_d;        // Sticky interrupt status.
    logic [1:0]  imsk_q, imsk_d;      // Interrupt mask.
    logic [31:0] prdata_q, prdata_d;  // Read data register.
    logic        pready_q, pready_d;  // Access acknowledge.
    logic        perr_q, perr_d;      // Error answer.
    logic        irq_q, irq_d;        // Registered interrupt.
    logic [7:0]  b0, b1, b2;          // Live record bytes.
    logic        err_lvl;             // Any error present.
    logic        err_rise, err_fall;  // Edges of the error level.
    logic        wr_acc, rd_acc;      // Access phase strobes.
    logic        hit;                 // Address is mapped.
    logic [1:0]  ev;                  // Interrupt events this cycle.

    // =====================================================================
    // Sub-blocks.
    // =====================================================================
    // One builder serves every function type, only the class differs.
    diag_rec_build u_build (
        .src      (err_src),
        .func_mod (ctrl_q[CTRL_FUNC]),
        .b0       (b0),
        .b1       (b1),
        .b2       (b2)
    );

    assign err_lvl = |err_src;

    diag_clear_det u_det (
        .mclk  (mclk),
        .rst_n (rst_n),
        .err   (err_lvl),
        .rise  (err_rise),
        .fall  (err_fall)
    );

    // =====================================================================
    // Record state and bus.
    // =====================================================================
    // The access phase has one wait cycle: pready rises on the second
    // cycle of every access, so each transfer takes three cycles with setup.
    always_comb begin
        wr_acc   = psel & penable & pwrite & ~pready_q;
        rd_acc   = psel & penable & ~pwrite & ~pready_q;
        st_d     = st_q;
        ctrl_d   = ctrl_q;
        r0_d     = r0_q;
        r1_d     = r1_q;
        r2_d     = r2_q;
        in3_d    = in3_q;
        rd_d     = rd_q;
        imsk_d   = imsk_q;
        ev       = 2'b00;
        pready_d = psel & penable & ~pready_q;
        perr_d   = 1'b0;
        prdata_d = 32'h0000_0000;
        hit      = 1'b1;
        case (paddr)
            ADDR_ERR_CAT:  prdata_d = {24'h000000, r0_q};
            ADDR_CLASS:    prdata_d = {24'h000000, r1_q};
            ADDR_INT_SUP:  prdata_d = {24'h000000, r2_q};
            ADDR_ZERO:     prdata_d = 32'h0000_0000;
            ADDR_IN_BYTE3: prdata_d = {24'h000000, in3_q};
            ADDR_CTRL:     prdata_d = {29'h0, ctrl_q};
            ADDR_STATUS:   prdata_d = {30'h0, err_lvl,
                                       st_q == ST_OUT};
            ADDR_IRQ_STAT: prdata_d = {30'h0, ist_q};
            ADDR_IRQ_MASK: prdata_d = {30'h0, imsk_q};
            ADDR_ERR_SRC:  prdata_d = {27'h0, err_src};
            default: begin
                hit = 1'b0;
            end
        endcase
        if (!rd_acc) begin
            prdata_d = prdata_q;
        end
        if ((rd_acc | wr_acc) && !hit) begin
            perr_d = 1'b1;
            prdata_d = 32'h0000_0000;
        end
        // Control writes; the acknowledge bit is a write-only strobe.
        if (wr_acc && paddr == ADDR_CTRL) begin
            ctrl_d = {1'b0, pwdata[CTRL_FUNC], pwdata[CTRL_REL]};
        end
        if (wr_acc && paddr == ADDR_IRQ_MASK) begin
            imsk_d = pwdata[1:0];
        end
        // Count collected bytes of the frozen record.
        if (st_q == ST_OUT && rd_acc) begin
            case (paddr)
                ADDR_ERR_CAT: rd_d[0] = 1'b1;
                ADDR_CLASS:   rd_d[1] = 1'b1;
                ADDR_INT_SUP: rd_d[2] = 1'b1;
                ADDR_ZERO:    rd_d[3] = 1'b1;
                default: begin
                    rd_d = rd_q;
                end
            endcase
        end
        case (st_q)
            ST_IDLE: begin
                if (err_rise) begin
                    // Incoming record: byte 3 carries the lost flag.
                    in3_d = 8'h00;
                    in3_d[B3_PILOST] = err_src[SRC_PILOST];
                    r0_d  = b0;
                    r1_d  = b1;
                    r2_d  = b2;
                    if (ctrl_q[CTRL_REL]) begin
                        ev[IRQ_IN] = 1'b1;
                    end
                    st_d = ST_ACT;
                end
            end
            ST_ACT: begin
                // Follow the error while it stands so the snapshot taken
                // at the clear reflects the latest causes.
                if (err_lvl) begin
                    r0_d = b0;
                    r1_d = b1;
                    r2_d = b2;
                end
                if (err_fall) begin
                    if (ctrl_q[CTRL_REL]) begin
                        ev[IRQ_OUT] = 1'b1;
                        rd_d = 4'h0;
                        st_d = ST_OUT;
                    end else begin
                        st_d = ST_IDLE;
                    end
                end
            end
            ST_OUT: begin
                // Bytes stay frozen until all four are read or software
                // forces the release; an error that rises meanwhile is not recorded.
                if (rd_q == 4'hf ||
                    (wr_acc && paddr == ADDR_CTRL &&
                     pwdata[CTRL_ACK])) begin
                    st_d = ST_IDLE;
                end
            end
            default: begin
                st_d = ST_IDLE;
            end
        endcase
        irq_d = |(ist_d & imsk_d);
    end

    // =====================================================================
    // Interrupt status: set beats write-one-to-clear.
    // =====================================================================
    always_comb begin
        ist_d = ist_q;
        if (wr_acc && paddr == ADDR_IRQ_STAT) begin
            ist_d = ist_q & ~pwdata[1:0];
        end
        ist_d = ist_d | ev;
    end

    // =====================================================================
    // Registers.
    // =====================================================================
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            st_q     <= ST_IDLE;
            ctrl_q   <= CTRL_RESET[2:0];
            r0_q     <= 8'h00;
            r1_q     <= 8'h00;
            r2_q     <= 8'h00;
            in3_q    <= 8'h00;
            rd_q     <= 4'h0;
            ist_q    <= 2'h0;
            imsk_q   <= MASK_RESET;
            prdata_q <= 32'h0000_0000;
            pready_q <= 1'b0;
            perr_q   <= 1'b0;
            irq_q    <= 1'b0;
        end else begin
            st_q     <= st_d;
            ctrl_q   <= ctrl_d;
            r0_q     <= r0_d;
            r1_q     <= r1_d;
            r2_q     <= r2_d;
            in3_q    <= in3_d;
            rd_q     <= rd_d;
            ist_q    <= ist_d;
            imsk_q   <= imsk_d;
            prdata_q <= prdata_d;
            pready_q <= pready_d;
            perr_q   <= perr_d;
            irq_q    <= irq_d;
        end
    end

    assign prdata  = prdata_q;
    assign pready  = pready_q;
    assign pslverr = perr_q;
    assign irq     = irq_q;
endmodule

// ### dv/diag_record_chk.sv
`timescale 1ns/10ps
// =============================================
// Port checker for the outgoing record block.
// =============================================
module diag_record_chk
    import diag_pkg::*;
(
    // Clock and reset.
    input wire logic        mclk,
    input wire logic        rst_n,
    // APB slave ports.
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr
);
    // First access cycle, where a request is taken.
    logic acc;
    // A taken read, whose data shows one cycle later.
    logic rd;
    assign acc = psel && penable && !pready;
    assign rd  = acc && !pwrite;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    AST_READY_NEXT: assert property (acc |=> pready)
        else $error("pready not one cycle after access");
    AST_READY_CAUSE: assert property ($rose(pready) |-> $past(acc))
        else $error("pready without a request");
    AST_READY_ONE: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    AST_ERR_PAIR: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    AST_UNMAPPED: assert property (acc && paddr > ADDR_ERR_SRC
        |=> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    AST_B0_FIX: assert property (rd && paddr == ADDR_ERR_CAT
        |=> prdata[31:5] == 27'h0)
        else $error("byte 0 upper bits not zero");
    AST_B0_FAIL: assert property (rd && paddr == ADDR_ERR_CAT
        |=> prdata[0] || prdata[4:1] == 4'h0)
        else $error("category flag without failure flag");
    AST_B1_CLASS: assert property (rd && paddr == ADDR_CLASS
        |=> prdata[3:0] inside {4'hf, 4'h8} || prdata == 32'h0)
        else $error("bad module class");
    AST_B2_FIX: assert property (rd && paddr == ADDR_INT_SUP
        |=> prdata[31:5] == 27'h0 && prdata[3:0] == 4'h0)
        else $error("byte 2 fixed bits not zero");
    AST_B3_ZERO: assert property (rd && paddr == ADDR_ZERO
        |=> prdata == 32'h0)
        else $error("byte 3 not zero");
endmodule

bind diag_record_out diag_record_chk chk (.mclk, .rst_n, .psel, .penable,
    .pwrite, .paddr, .prdata, .pready, .pslverr);

// ### dv/diag_reader.sv
`timescale 1ns/10ps
// =============================================
// Diagnostic handler model: an APB master.
// =============================================
module diag_reader (
    // Clock.
    input wire logic        mclk,
    // APB master side.
    output logic            psel,
    output logic            penable,
    output logic            pwrite,
    output logic     [11:0] paddr,
    output logic     [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr
);
    // Idle bus at time zero.
    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 12'hfff;
        pwdata  = 32'h0;
    end
    // One transfer; the record is collected by four such reads.
    // Released lines show inverted data so stale values never match.
    task automatic xfer(input logic w, input logic [11:0] a,
        input logic [31:0] d, output logic [31:0] r, output logic e);
        int n;
        n = 0;
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 32);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        paddr   <= ~a;
        pwdata  <= ~d;
        @(posedge mclk);
    endtask
endmodule

// ### dv/test_diag_record_out.sv
`timescale 1ns/10ps
// =============================================
// Bench for the outgoing diagnostic record.
// =============================================
module test_diag_record_out
    import diag_pkg::*;
;
    logic             mclk;
    logic             rst_n;
    logic             psel;
    logic             penable;
    logic             pwrite;
    logic [11:0]      paddr;
    logic [31:0]      pwdata;
    logic [31:0]      prdata;
    logic             pready;
    logic             pslverr;
    logic [SRC_W-1:0] err_src;
    logic             irq;
    logic [31:0]      rdv;
    logic             rerr;
    int               fails;
    int               total_checks;
    diag_record_out dut (.mclk, .rst_n, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .err_src, .irq);
    diag_reader rdr (.mclk, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr);
    // 40 MHz clock.
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    // Compare and count.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        rdr.xfer(1'b1, a, d, rdv, rerr);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        rdr.xfer(1'b0, a, 32'h0, rdv, rerr);
        chk(rdv, e);
    endtask
    // Let registered outputs settle before looking at irq.
    task automatic irq_is(input logic e);
        repeat (2) @(posedge mclk);
        chk({31'h0, irq}, {31'h0, e});
    endtask
    task automatic tally_and_finish;
        if (fails == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // Reset state, a reserved write and an unmapped access.
    task automatic t_reset;
        rd(ADDR_ERR_CAT, 32'h0);
        rd(ADDR_CTRL, CTRL_RESET);
        wr(ADDR_ZERO, 32'hff);
        rd(ADDR_ZERO, 32'h0);
        rd(12'h028, 32'h0);
        chk({31'h0, rerr}, 32'h1);
        irq_is(1'b0);
    endtask
    // Each source alone, then all; both module classes.
    task automatic t_record;
        logic [SRC_W-1:0] s;
        logic [31:0]      e0;
        logic [31:0]      e1;
        wr(ADDR_IRQ_MASK, 32'h3);
        for (int i = 0; i < 6; i++) begin
            s  = (i == 5) ? 5'h1f : 5'h01 << i;
            e0 = {27'h0, {3{s[3]}}, s[1] | s[2], |s};
            e1 = {27'h0, |s, i[0] ? CLASS_FUNCTION : CLASS_DIGITAL};
            wr(ADDR_CTRL, {30'h0, i[0], 1'b1});
            err_src <= s;
            repeat (4) @(posedge mclk);
            rd(ADDR_IN_BYTE3, {25'h0, s[0], 6'h0});
            err_src <= '0;
            irq_is(1'b1);
            rd(ADDR_STATUS, 32'h1);
            rd(ADDR_ERR_CAT, e0);
            rd(ADDR_CLASS, e1);
            rd(ADDR_INT_SUP, {27'h0, s[1], 4'h0});
            rd(ADDR_ZERO, 32'h0);
            rd(ADDR_STATUS, 32'h0);
            rd(ADDR_IRQ_STAT, 32'h3);
            wr(ADDR_IRQ_STAT, 32'h3);
            irq_is(1'b0);
        end
    endtask
    // With release off a cleared error leaves no record.
    task automatic t_no_release;
        wr(ADDR_CTRL, 32'h0);
        err_src <= 5'h02;
        repeat (4) @(posedge mclk);
        rd(ADDR_STATUS, 32'h2);
        err_src <= '0;
        repeat (4) @(posedge mclk);
        rd(ADDR_STATUS, 32'h0);
        rd(ADDR_IRQ_STAT, 32'h0);
    endtask
    // Masking, W1C clearing and the explicit acknowledge.
    task automatic t_mask;
        wr(ADDR_IRQ_MASK, 32'h0);
        wr(ADDR_CTRL, 32'h1);
        err_src <= 5'h08;
        repeat (4) @(posedge mclk);
        err_src <= '0;
        irq_is(1'b0);
        wr(ADDR_IRQ_MASK, 32'h1);
        irq_is(1'b1);
        wr(ADDR_IRQ_STAT, 32'h1);
        irq_is(1'b0);
        rd(ADDR_STATUS, 32'h1);
        wr(ADDR_CTRL, 32'h5);
        rd(ADDR_STATUS, 32'h0);
    endtask
    // Main sequence.
    initial begin
        fails        = 0;
        total_checks = 0;
        rst_n        = 1'b0;
        err_src      = '0;
        repeat (8) @(posedge mclk);
        rst_n <= 1'b1;
        @(posedge mclk);
        t_reset();
        t_record();
        t_no_release();
        t_mask();
        tally_and_finish();
    end
    // The run needs well under 2000 cycles.
    initial begin
        repeat (5000) @(posedge mclk);
        fails++;
        tally_and_finish();
    end
endmodule
